// ### design/exec_pkg.sv
package exec_pkg;

  // Byte offsets of the register words on the bus.
  localparam logic [7:0] CMD_OFS     = 8'h00;
  localparam logic [7:0] FLAG_OFS    = 8'h04;
  localparam logic [7:0] PC_OFS      = 8'h08;
  localparam logic [7:0] OPND_OFS    = 8'h0c;
  localparam logic [7:0] STAT_OFS    = 8'h10;
  localparam logic [7:0] IO_BASE_OFS = 8'h20;
  localparam int         IO_COUNT    = 8;

  // Field positions inside the command word.
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OFF_LSB = 8;
  localparam int CMD_IO_LSB  = 16;
  localparam int CMD_BIT_LSB = 24;

  // Field positions inside the status word.
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB   = 8;

  // Flag positions in the flag word.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  FLAG_RESET = 8'h00;
  localparam logic [7:0]  OPND_RESET = 8'h00;
  localparam logic [7:0]  IO_RESET   = 8'h00;

  // Execution lengths in clock cycles.
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    branch_half_carry_clear    = 4'h0,
    branch_transfer_flag_set   = 4'h1,
    branch_transfer_flag_clear = 4'h2,
    branch_overflow_set        = 4'h3,
    branch_overflow_clear      = 4'h4,
    branch_interrupts_enabled  = 4'h5,
    branch_interrupts_disabled = 4'h6,
    io_bit_set_op              = 4'h7,
    io_bit_clear_op            = 4'h8,
    shift_left_logical_op      = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_first  = 2'b01,
    st_second = 2'b10
  } state_t;

  typedef struct packed {
    logic [2:0] bit_sel;
    logic [2:0] io_sel;
    logic [6:0] offset;
    op_t        op;
  } cmd_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [7:0]  opnd;
    logic [7:0]  io_val;
    logic        io_wr;
    logic        taken;
    logic [1:0]  cycles;
  } result_t;

endpackage

// ### design/exec_unit.sv
`timescale 1ns/10ps
module exec_unit
(
  input  exec_pkg::cmd_t    cmd,
  input  logic [15:0]       pc,
  input  logic [7:0]        flags,
  input  logic [7:0]        opnd,
  input  logic [7:0]        io_val,
  output exec_pkg::result_t res
);
  import exec_pkg::*;

  logic        is_branch;
  logic        cond;
  logic [15:0] target;
  logic [7:0]  mask;

  assign target = pc + {{9{cmd.offset[6]}}, cmd.offset} + 16'h0001;
  assign mask   = 8'h01 << cmd.bit_sel;

  always_comb
  begin
    res        = '0;
    res.pc     = pc;
    res.flags  = flags;
    res.opnd   = opnd;
    res.io_val = io_val;
    res.cycles = CYC_ONE;
    is_branch  = 1'b1;
    cond       = 1'b0;
    case (cmd.op)
      branch_half_carry_clear:    cond = !flags[FLAG_H];
      branch_transfer_flag_set:   cond = flags[FLAG_T];
      branch_transfer_flag_clear: cond = !flags[FLAG_T];
      branch_overflow_set:        cond = flags[FLAG_V];
      branch_overflow_clear:      cond = !flags[FLAG_V];
      branch_interrupts_enabled:  cond = flags[FLAG_I];
      branch_interrupts_disabled: cond = !flags[FLAG_I];
      io_bit_set_op:
      begin
        is_branch  = 1'b0;
        res.io_val = io_val | mask;
        res.io_wr  = 1'b1;
        res.cycles = CYC_TWO;
      end
      io_bit_clear_op:
      begin
        is_branch  = 1'b0;
        res.io_val = io_val & ~mask;
        res.io_wr  = 1'b1;
        res.cycles = CYC_TWO;
      end
      shift_left_logical_op:
      begin
        is_branch           = 1'b0;
        res.opnd            = {opnd[6:0], 1'b0};
        res.flags[FLAG_C]   = opnd[7];
        res.flags[FLAG_N]   = opnd[6];
        res.flags[FLAG_Z]   = (opnd[6:0] == 7'h00);
        res.flags[FLAG_V]   = opnd[6] ^ opnd[7];
      end
      default: is_branch = 1'b0;
    endcase
    // Branches never touch the flags; only the target, taken bit and length differ.
    if (is_branch && cond)
    begin
      res.pc     = target;
      res.taken  = 1'b1;
      res.cycles = CYC_TWO;
    end
  end

endmodule

// ### design/flag_branch_and_io_bit_ops.sv
`timescale 1ns/10ps
module flag_branch_and_io_bit_ops
(
  input  logic        clk,
  input  logic        rst_b,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  output logic        busy
);
  import exec_pkg::*;

  logic                      wr_pend_reg;
  logic                      wr_pend_next;
  logic [7:0]                addr_reg;
  logic [7:0]                addr_next;
  logic [31:0]               hrdata_reg;
  logic [31:0]               hrdata_next;
  logic                      hreadyout_reg;
  logic                      busy_reg;
  logic                      accept;
  logic                      mapped;

  state_t                    state_reg;
  state_t                    state_next;
  cmd_t                      cmd_reg;
  cmd_t                      cmd_next;
  logic [15:0]               pc_reg;
  logic [15:0]               pc_next;
  logic [7:0]                flags_reg;
  logic [7:0]                flags_next;
  logic [7:0]                opnd_reg;
  logic [7:0]                opnd_next;
  logic                      taken_reg;
  logic                      taken_next;
  logic [1:0]                last_cyc_reg;
  logic [1:0]                last_cyc_next;
  logic [IO_COUNT-1:0][7:0]  io_reg;
  logic [IO_COUNT-1:0][7:0]  io_next;
  logic                      apply;
  logic                      bus_wr;
  result_t                   res;

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = 1'b0;
  assign busy      = busy_reg;

  // The slave never stalls, so every data phase is the cycle after its address phase.
  assign accept = hsel && hready && htrans[1];
  assign mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign bus_wr = wr_pend_reg && (state_reg == st_idle);

  always_comb
  begin
    wr_pend_next = accept && hwrite && (hsize == HSIZE_WORD) && mapped;
    addr_next    = accept ? haddr[7:0] : addr_reg;
    hrdata_next  = 32'h00000000;
    if (accept && !hwrite && mapped)
    begin
      if (haddr[7:5] == IO_BASE_OFS[7:5])
      begin
        hrdata_next[7:0] = io_reg[haddr[4:2]];
      end
      else
      begin
        case (haddr[7:0])
          CMD_OFS:
          begin
            hrdata_next[CMD_OP_LSB +: 4]  = cmd_reg.op;
            hrdata_next[CMD_OFF_LSB +: 7] = cmd_reg.offset;
            hrdata_next[CMD_IO_LSB +: 3]  = cmd_reg.io_sel;
            hrdata_next[CMD_BIT_LSB +: 3] = cmd_reg.bit_sel;
          end
          FLAG_OFS: hrdata_next[7:0]  = flags_reg;
          PC_OFS:   hrdata_next[15:0] = pc_reg;
          OPND_OFS: hrdata_next[7:0]  = opnd_reg;
          STAT_OFS:
          begin
            hrdata_next[STAT_BUSY_BIT]      = busy_reg;
            hrdata_next[STAT_TAKEN_BIT]     = taken_reg;
            hrdata_next[STAT_CYC_LSB +: 2]  = last_cyc_reg;
          end
          default: hrdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_pend_reg   <= 1'b0;
      addr_reg      <= 8'h00;
      hrdata_reg    <= 32'h00000000;
      hreadyout_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg   <= wr_pend_next;
      addr_reg      <= addr_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= 1'b1;
    end
  end

  exec_unit u_exec
  (
    .cmd    (cmd_reg),
    .pc     (pc_reg),
    .flags  (flags_reg),
    .opnd   (opnd_reg),
    .io_val (io_reg[cmd_reg.io_sel]),
    .res    (res)
  );

  // Bus writes are dropped while busy, so the executing operands stay frozen.
  always_comb
  begin
    state_next    = state_reg;
    cmd_next      = cmd_reg;
    pc_next       = pc_reg;
    flags_next    = flags_reg;
    opnd_next     = opnd_reg;
    taken_next    = taken_reg;
    last_cyc_next = last_cyc_reg;
    apply         = 1'b0;
    case (state_reg)
      st_idle:
      begin
        if (bus_wr)
        begin
          case (addr_reg)
            CMD_OFS:
            begin
              cmd_next.op      = op_t'(hwdata[CMD_OP_LSB +: 4]);
              cmd_next.offset  = hwdata[CMD_OFF_LSB +: 7];
              cmd_next.io_sel  = hwdata[CMD_IO_LSB +: 3];
              cmd_next.bit_sel = hwdata[CMD_BIT_LSB +: 3];
              state_next       = st_first;
            end
            FLAG_OFS: flags_next = hwdata[7:0];
            PC_OFS:   pc_next    = hwdata[15:0];
            OPND_OFS: opnd_next  = hwdata[7:0];
            default:  state_next = st_idle;
          endcase
        end
      end
      st_first:
      begin
        if (res.cycles == CYC_TWO)
        begin
          state_next = st_second;
        end
        else
        begin
          apply         = 1'b1;
          last_cyc_next = CYC_ONE;
        end
      end
      st_second:
      begin
        apply         = 1'b1;
        last_cyc_next = CYC_TWO;
      end
      default: state_next = st_idle;
    endcase
    if (apply)
    begin
      state_next = st_idle;
      pc_next    = res.pc;
      flags_next = res.flags;
      opnd_next  = res.opnd;
      taken_next = res.taken;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IO_COUNT; gi++)
    begin : g_io
      assign io_next[gi] =
        (apply && res.io_wr && (cmd_reg.io_sel == 3'(gi))) ? res.io_val :
        (bus_wr && (addr_reg[7:5] == IO_BASE_OFS[7:5]) && (addr_reg[4:2] == 3'(gi))) ?
        hwdata[7:0] : io_reg[gi];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg    <= st_idle;
      cmd_reg      <= '0;
      pc_reg       <= PC_RESET;
      flags_reg    <= FLAG_RESET;
      opnd_reg     <= OPND_RESET;
      taken_reg    <= 1'b0;
      last_cyc_reg <= 2'h0;
      io_reg       <= {IO_COUNT{IO_RESET}};
      busy_reg     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      cmd_reg      <= cmd_next;
      pc_reg       <= pc_next;
      flags_reg    <= flags_next;
      opnd_reg     <= opnd_next;
      taken_reg    <= taken_next;
      last_cyc_reg <= last_cyc_next;
      io_reg       <= io_next;
      busy_reg     <= (state_next != st_idle);
    end
  end

  logic [15:0] br_target;
  logic [7:0]  io_cur;
  logic [7:0]  bit_mask;
  logic        in_first;

  assign br_target = pc_reg + {{9{cmd_reg.offset[6]}}, cmd_reg.offset} + 16'h0001;
  assign io_cur    = io_reg[cmd_reg.io_sel];
  assign bit_mask  = 8'h01 << cmd_reg.bit_sel;
  assign in_first  = (state_reg == st_first);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  hc_clear_taken_a: assert property (
    in_first && cmd_reg.op == branch_half_carry_clear && !flags_reg[FLAG_H]
    |=> state_reg == st_second ##1
    (state_reg == st_idle && pc_reg == $past(br_target, 2) && $stable(flags_reg)))
    else $error("half-carry-clear branch wrong target or length");

  tset_skip_a: assert property (
    in_first && cmd_reg.op == branch_transfer_flag_set && !flags_reg[FLAG_T]
    |=> state_reg == st_idle && $stable(pc_reg) && $stable(flags_reg))
    else $error("transfer-set branch not skipped in one cycle");

  tclr_taken_a: assert property (
    in_first && cmd_reg.op == branch_transfer_flag_clear && !flags_reg[FLAG_T]
    |-> ##2 pc_reg == $past(br_target, 2))
    else $error("transfer-clear branch wrong target");

  vset_taken_a: assert property (
    in_first && cmd_reg.op == branch_overflow_set && flags_reg[FLAG_V]
    |-> ##2 pc_reg == $past(br_target, 2) && taken_reg)
    else $error("overflow-set branch wrong target");

  vclr_skip_a: assert property (
    in_first && cmd_reg.op == branch_overflow_clear && flags_reg[FLAG_V]
    |=> !busy_reg && !taken_reg && $stable(pc_reg) && last_cyc_reg == CYC_ONE)
    else $error("overflow-clear branch not skipped");

  ie_taken_a: assert property (
    in_first && cmd_reg.op == branch_interrupts_enabled && flags_reg[FLAG_I]
    |=> busy_reg ##1 (!busy_reg && last_cyc_reg == CYC_TWO))
    else $error("interrupts-enabled branch length wrong");

  id_skip_a: assert property (
    in_first && cmd_reg.op == branch_interrupts_disabled && flags_reg[FLAG_I]
    |=> $stable(pc_reg) && state_reg == st_idle)
    else $error("interrupts-disabled branch taken wrongly");

  io_set_bit_a: assert property (
    in_first && cmd_reg.op == io_bit_set_op
    |=> busy_reg ##1 (io_cur == ($past(io_cur, 2) | $past(bit_mask, 2))
    && $stable(flags_reg) && !busy_reg))
    else $error("bit set result or length wrong");

  io_clr_bit_a: assert property (
    in_first && cmd_reg.op == io_bit_clear_op
    |=> busy_reg ##1 (io_cur == ($past(io_cur, 2) & ~$past(bit_mask, 2))
    && $stable(flags_reg)))
    else $error("bit clear result or length wrong");

  shift_left_a: assert property (
    in_first && cmd_reg.op == shift_left_logical_op
    |=> opnd_reg == {$past(opnd_reg[6:0]), 1'b0} && flags_reg[FLAG_C] == $past(opnd_reg[7])
    && flags_reg[FLAG_Z] == (opnd_reg == 8'h00) && !busy_reg)
    else $error("shift left result or flags wrong");

endmodule

// ### verif/flag_branch_and_io_bit_ops_test.sv
`timescale 1ns/10ps
module flag_branch_and_io_bit_ops_test;
  import exec_pkg::*;

  // A mismatch is counted and reported at once, so one bad value never hides behind another.
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end

  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        busy;
  int          fail_count;
  int          samples_checked;

  flag_branch_and_io_bit_ops u_flag_branch_and_io_bit_ops
  (
    .clk       (clk),
    .rst_b     (rst_b),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .busy      (busy)
  );

  always #5 clk = ~clk;

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Ready is looked at half a cycle early, where it has settled for the coming edge.
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 50)
    begin
      fail_count++;
      $display("CHECK FAILED hreadyout expected 1 seen %b", hreadyout);
      end_sim();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, input logic [2:0] sz);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= sz;
    wait_ready();
    @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h00000000;
    wait_ready();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
    @(posedge clk);
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {24'h000000, a}, d, x, HSIZE_WORD);
  endtask

  task automatic get(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, {24'h000000, a}, 32'h00000000, d, HSIZE_WORD);
  endtask

  function automatic logic [31:0] mk_cmd(input op_t op, input logic [6:0] k,
                                         input logic [2:0] io, input logic [2:0] b);
    return (32'(op) << CMD_OP_LSB) | (32'(k) << CMD_OFF_LSB) |
           (32'(io) << CMD_IO_LSB) | (32'(b) << CMD_BIT_LSB);
  endfunction

  // The busy pin is counted cycle by cycle, and the status read must report the same length.
  task automatic exec(input logic [31:0] c, input int cyc);
    int          n;
    logic [31:0] s;
    put(CMD_OFS, c);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 10)
    begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
    `CHK("busy cycles", cyc, n)
    get(STAT_OFS, s);
    `CHK("status cycles", 2'(cyc), s[STAT_CYC_LSB +: 2])
  endtask

  task automatic test_reset();
    logic [31:0] r;
    int          n;
    get(PC_OFS, r);
    `CHK("pc reset", {16'h0000, PC_RESET}, r)
    get(FLAG_OFS, r);
    `CHK("flag reset", {24'h000000, FLAG_RESET}, r)
    for (n = 0; n < IO_COUNT; n++)
    begin
      get(IO_BASE_OFS + {n[5:0], 2'b00}, r);
      `CHK("io reset", {24'h000000, IO_RESET}, r)
    end
    bus(1'b0, 32'h00000100, 32'h00000000, r, HSIZE_WORD);
    `CHK("unmapped read", 32'h00000000, r)
    $display("reset test done");
  endtask

  // Every branch runs once taken and once not, with forward wrap and backward offsets.
  task automatic test_branches();
    int          i;
    int          t;
    int          pos;
    logic        want;
    logic        take;
    logic [7:0]  f;
    logic [6:0]  k;
    logic [15:0] pc0;
    logic [15:0] pce;
    logic [31:0] r;
    for (i = 0; i < 7; i++)
    begin
      for (t = 0; t < 2; t++)
      begin
        pos  = (i == 0) ? FLAG_H : (i < 3) ? FLAG_T : (i < 5) ? FLAG_V : FLAG_I;
        want = (i == 1 || i == 3 || i == 5);
        take = t[0];
        f = 8'h5a;
        f[pos] = take ? want : ~want;
        k   = i[0] ? 7'h40 : 7'h3f;
        pc0 = i[0] ? 16'h0010 : 16'hfff0;
        pce = take ? pc0 + {{9{k[6]}}, k} + 16'h0001 : pc0;
        put(FLAG_OFS, {24'h000000, f});
        put(PC_OFS, {16'h0000, pc0});
        exec(mk_cmd(op_t'(i), k, 3'h0, 3'h0), take ? 2 : 1);
        get(PC_OFS, r);
        `CHK("branch pc", pce, r[15:0])
        get(FLAG_OFS, r);
        `CHK("branch flags", f, r[7:0])
        get(STAT_OFS, r);
        `CHK("branch taken", take, r[STAT_TAKEN_BIT])
      end
    end
    $display("branch test done");
  endtask

  task automatic test_io();
    int          n;
    logic [7:0]  v;
    logic [7:0]  a;
    logic [31:0] r;
    put(FLAG_OFS, 32'h000000c3);
    for (n = 0; n < IO_COUNT; n++)
    begin
      a = IO_BASE_OFS + {n[5:0], 2'b00};
      v = 8'h5a ^ {n[3:0], n[3:0]};
      put(a, {24'h000000, v});
      exec(mk_cmd(io_bit_set_op, 7'h00, n[2:0], n[2:0]), 2);
      get(a, r);
      `CHK("io set", {24'h000000, v | (8'h01 << n)}, r)
      exec(mk_cmd(io_bit_clear_op, 7'h00, n[2:0], n[2:0]), 2);
      get(a, r);
      `CHK("io clear", {24'h000000, v & ~(8'h01 << n)}, r)
    end
    get(FLAG_OFS, r);
    `CHK("io flags", 32'h000000c3, r)
    $display("io bit test done");
  endtask

  task automatic test_shift();
    logic [7:0]  vals [4];
    logic [7:0]  e;
    logic [7:0]  ef;
    logic [31:0] r;
    int          i;
    vals = '{8'h81, 8'h80, 8'h40, 8'hc0};
    for (i = 0; i < 4; i++)
    begin
      put(OPND_OFS, {24'h000000, vals[i]});
      put(FLAG_OFS, 32'h00000075);
      exec(mk_cmd(shift_left_logical_op, 7'h00, 3'h0, 3'h0), 1);
      e  = {vals[i][6:0], 1'b0};
      ef = 8'h75;
      ef[FLAG_C] = vals[i][7];
      ef[FLAG_N] = e[7];
      ef[FLAG_V] = e[7] ^ vals[i][7];
      ef[FLAG_Z] = (e == 8'h00);
      get(OPND_OFS, r);
      `CHK("shift result", e, r[7:0])
      get(FLAG_OFS, r);
      `CHK("shift flags", ef, r[7:0])
    end
    $display("shift test done");
  endtask

  // Writes while busy, narrow or misaligned writes and spare op codes must leave state alone.
  task automatic test_refused();
    logic [31:0] r;
    put(PC_OFS, 32'h00001234);
    put(IO_BASE_OFS + 8'h1c, 32'h00000000);
    put(CMD_OFS, mk_cmd(io_bit_set_op, 7'h00, 3'h7, 3'h7));
    put(PC_OFS, 32'h0000beef);
    bus(1'b1, {24'h000000, PC_OFS}, 32'h00005678, r, 3'h1);
    put(PC_OFS + 8'h01, 32'h00009abc);
    put(STAT_OFS, 32'hffffffff);
    get(PC_OFS, r);
    `CHK("refused pc", 32'h00001234, r)
    get(IO_BASE_OFS + 8'h1c, r);
    `CHK("set under busy", 32'h00000080, r)
    get(STAT_OFS, r);
    `CHK("status read only", 32'(CYC_TWO) << STAT_CYC_LSB, r)
    exec(mk_cmd(op_t'(4'ha), 7'h15, 3'h0, 3'h0), 1);
    get(PC_OFS, r);
    `CHK("spare op pc", 32'h00001234, r)
    $display("refused write test done");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("CHECK FAILED watchdog expected done seen hang");
    end_sim();
  end

  initial
  begin
    clk             = 1'b0;
    rst_b           = 1'b0;
    hsel            = 1'b0;
    haddr           = 32'h00000000;
    htrans          = 2'b00;
    hwrite          = 1'b0;
    hsize           = HSIZE_WORD;
    hwdata          = 32'h00000000;
    fail_count      = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    test_reset();
    test_branches();
    test_io();
    test_shift();
    test_refused();
    end_sim();
  end
endmodule
